// >>> csh_pkg.sv
// package of constants and carrier types for the configuration status handshake
// assumes a single 10 MHz clock domain and no software-visible registers
package csh_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int POR_SHORT_MS = 12;
	localparam int POR_LONG_MS = 100;
	localparam int POR_SHORT_CYC = POR_SHORT_MS * (CLK_HZ / 1000);
	localparam int POR_LONG_CYC = POR_LONG_MS * (CLK_HZ / 1000);
	localparam int POR_CNT_W = 21;
	localparam int SYNC_STAGES = 3;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic RST_DRIVE_LOW = 1'h1;
	localparam logic RST_RELEASED = 1'h1;
	localparam logic RST_PIN_LOW = 1'h0;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		CSH_POR = 6'h01,
		CSH_WAIT_START = 6'h02,
		CSH_LOAD = 6'h04,
		CSH_INIT = 6'h08,
		CSH_USER = 6'h10,
		CSH_ERROR = 6'h20
	} csh_state_t;

	// open-drain pin as drive data and drive enable
	typedef struct packed {
		logic out;
		logic oe;
	} csh_od_t;

	// filtered pin levels
	typedef struct packed {
		logic status_n;
		logic complete;
		logic select_n;
		logic reconfig_n;
	} csh_pins_t;

endpackage : csh_pkg

// >>> csh_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the input is asynchronous to clock_i
`timescale 1ns/10ps
`default_nettype none
module csh_sync #(
	parameter logic RST_VAL = 1'h1
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] stage;

	// stages and level reset to the pin's idle level, so no false change follows reset
	// stage[0] is read only by stage[1]
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage <= {3{RST_VAL}};
		end else begin
			stage <= {stage[1:0], pin_i};
		end
	end

	// a change counts only when stages two and three agree
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_o <= RST_VAL;
		end else if (stage[1] == stage[2]) begin
			level_o <= stage[2];
		end
	end

endmodule : csh_sync
`default_nettype wire

// >>> csh_config_status.sv
// configuration status handshake: status, done, chip enable and chain enable
// assumes external pull-ups on the open-drain lines; wire level fed back on *_i
//
// Behaviour
// R1: hold status low while power-on reset pending; release after interval expires.
// R2: a status rise before power-on reset trips starts no valid configuration.
// R3: with supplies valid but reset not tripped, pull status low.
// R4: status released high at reset trip; that rise starts fresh configuration.
// R5: drive done line low from before configuration until configuration finishes.
// R6: release done only after complete error-free data and initialization started.
// R7: sense done line; enter user mode only when data complete and line high.
// R8: after initialization, ignore external low on done line; keep configuration.
// R9: accept configuration only while chip enable input is low.
// R10: system keeps chip enable low through configuration, initialization, user mode.
// R11: single device has chip enable tied permanently low.
// R12: chain: first enable tied low; each chain output feeds next enable.
// R13: chip enable held low during boundary-scan programming.
// R14: external status low in load or init means error; device pulls status low.
// R15: reconfig low in user mode clears and resets; returning high restarts.
// R16: drive chain-enable output low once own configuration is complete.
// R17: status and done only ever driven low, otherwise released.
`timescale 1ns/10ps
`default_nettype none
module csh_config_status #(
	parameter int POR_SHORT = csh_pkg::POR_SHORT_CYC,
	parameter int POR_LONG = csh_pkg::POR_LONG_CYC
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic supply_ok_i,
	input wire logic por_short_sel_i,
	input wire logic config_status_n_i,
	output logic config_status_n_o,
	output logic config_status_n_oe,
	input wire logic config_complete_flag_i,
	output logic config_complete_flag_o,
	output logic config_complete_flag_oe,
	input wire logic chip_select_in_n_i,
	input wire logic reconfig_request_n_i,
	output logic chain_select_out_n_o,
	input wire logic data_done_i,
	input wire logic data_error_i,
	output logic load_enable_o,
	output logic user_mode_o,
	output logic error_o
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	csh_pkg::csh_pins_t pins;
	logic supply_ok;
	logic porsel_pin;

	// pulled-up lines idle high; supply and strap idle low
	csh_sync #(.RST_VAL(csh_pkg::RST_RELEASED)) u_sync_status (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(config_status_n_i), .level_o(pins.status_n));
	csh_sync #(.RST_VAL(csh_pkg::RST_RELEASED)) u_sync_done (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(config_complete_flag_i), .level_o(pins.complete));
	csh_sync #(.RST_VAL(csh_pkg::RST_RELEASED)) u_sync_sel (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(chip_select_in_n_i), .level_o(pins.select_n));
	csh_sync #(.RST_VAL(csh_pkg::RST_RELEASED)) u_sync_recfg (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(reconfig_request_n_i), .level_o(pins.reconfig_n));
	csh_sync #(.RST_VAL(csh_pkg::RST_PIN_LOW)) u_sync_supply (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(supply_ok_i), .level_o(supply_ok));
	csh_sync #(.RST_VAL(csh_pkg::RST_PIN_LOW)) u_sync_porsel (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .pin_i(por_short_sel_i), .level_o(porsel_pin));

	// ---------------------------------------------------------------
	// power-on reset timer
	// ---------------------------------------------------------------
	logic [csh_pkg::POR_CNT_W-1:0] por_cnt;
	logic [csh_pkg::POR_CNT_W-1:0] por_limit;
	logic por_done;
	logic porsel;

	// strap sampled by a clocked process, not by the reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			porsel <= 1'h0;
		end else if (por_cnt == '0) begin
			porsel <= porsel_pin;
		end
	end

	assign por_limit = porsel ? csh_pkg::POR_CNT_W'(POR_SHORT) : csh_pkg::POR_CNT_W'(POR_LONG);

	// timer only runs once supplies are valid; a dip restarts it
	// limitation: the counter width covers the long interval only at clocks up to about 20 MHz
	// the count starts after the supply synchroniser, so release lags the pin by ~4 cycles
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_cnt <= '0;
			por_done <= 1'h0;
		end else if (!supply_ok) begin
			por_cnt <= '0;
			por_done <= 1'h0;
		end else if (!por_done) begin
			if (por_cnt >= por_limit - csh_pkg::POR_CNT_W'(1)) begin
				por_done <= 1'h1; // R1
			end else begin
				por_cnt <= por_cnt + csh_pkg::POR_CNT_W'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	csh_pkg::csh_state_t state;
	csh_pkg::csh_state_t next_state;
	logic status_q;

	// previous status level for rising-edge detection
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_q <= 1'h1;
		end else begin
			status_q <= pins.status_n;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			csh_pkg::CSH_POR: begin
				// a high line before the trip is ignored here
				if (por_done) begin
					next_state = csh_pkg::CSH_WAIT_START; // R2
				end
			end
			csh_pkg::CSH_WAIT_START: begin
				if (!pins.reconfig_n) begin
					next_state = csh_pkg::CSH_POR;
				end else if (pins.status_n && !status_q) begin
					next_state = csh_pkg::CSH_LOAD; // R4
				end else if (pins.status_n) begin
					next_state = csh_pkg::CSH_LOAD;
				end
			end
			csh_pkg::CSH_LOAD: begin
				if (!pins.reconfig_n) begin
					next_state = csh_pkg::CSH_POR;
				end else if (data_error_i || !pins.status_n) begin
					next_state = csh_pkg::CSH_ERROR; // R14
				end else if (data_done_i && !pins.select_n) begin
					next_state = csh_pkg::CSH_INIT; // R6
				end
			end
			csh_pkg::CSH_INIT: begin
				if (!pins.reconfig_n) begin
					next_state = csh_pkg::CSH_POR;
				end else if (!pins.status_n) begin
					next_state = csh_pkg::CSH_ERROR; // R14
				end else if (pins.complete) begin
					next_state = csh_pkg::CSH_USER; // R7
				end
			end
			csh_pkg::CSH_USER: begin
				// status and done lows are ignored in user mode
				if (!pins.reconfig_n) begin
					next_state = csh_pkg::CSH_POR; // R15 R8
				end
			end
			csh_pkg::CSH_ERROR: begin
				if (!pins.reconfig_n) begin
					next_state = csh_pkg::CSH_POR;
				end
			end
			default: begin
				next_state = csh_pkg::CSH_POR;
			end
		endcase
		// a pending timer or a held reconfig request keeps the device in reset;
		// deciding it here keeps the registered pin drives in step with the state
		if (!pins.reconfig_n || !por_done) begin
			next_state = csh_pkg::CSH_POR; // R1 R3 R15
		end
	end

	// reconfig low parks the machine in POR; high again leaves POR at once, as the timer stays done
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= csh_pkg::CSH_POR;
		end else if (!pins.reconfig_n) begin
			state <= csh_pkg::CSH_POR; // R15
		end else begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// open-drain and status outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_status_n_oe <= csh_pkg::RST_DRIVE_LOW;
			config_complete_flag_oe <= csh_pkg::RST_DRIVE_LOW;
			chain_select_out_n_o <= csh_pkg::RST_RELEASED;
			load_enable_o <= 1'h0;
			user_mode_o <= 1'h0;
			error_o <= 1'h0;
		end else begin
			// held low until timer done and no reconfig request
			config_status_n_oe <= (next_state == csh_pkg::CSH_POR) ||
				(next_state == csh_pkg::CSH_ERROR); // R1 R3 R14
			config_complete_flag_oe <= (next_state == csh_pkg::CSH_POR) ||
				(next_state == csh_pkg::CSH_WAIT_START) ||
				(next_state == csh_pkg::CSH_LOAD) ||
				(next_state == csh_pkg::CSH_ERROR); // R5 R6
			chain_select_out_n_o <= !((next_state == csh_pkg::CSH_INIT) ||
				(next_state == csh_pkg::CSH_USER)); // R16 R12
			load_enable_o <= (next_state == csh_pkg::CSH_LOAD) && !pins.select_n; // R9
			user_mode_o <= (next_state == csh_pkg::CSH_USER);
			error_o <= (next_state == csh_pkg::CSH_ERROR);
		end
	end

	// only ever low or released
	assign config_status_n_o = 1'h0; // R17
	assign config_complete_flag_o = 1'h0; // R17

endmodule : csh_config_status
`default_nettype wire

// >>> csh_config_status_assertions.sv
// checker for the configuration status handshake top module
// assumes binding to csh_config_status; ports mirror its own
`timescale 1ns/10ps
`default_nettype none
module csh_config_status_assertions #(
	parameter int POR_SHORT = 20,
	parameter int POR_LONG = 40
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic supply_ok_i,
	input wire logic por_short_sel_i,
	input wire logic config_status_n_o,
	input wire logic config_status_n_oe,
	input wire logic config_complete_flag_i,
	input wire logic config_complete_flag_o,
	input wire logic config_complete_flag_oe,
	input wire logic chip_select_in_n_i,
	input wire logic reconfig_request_n_i,
	input wire logic chain_select_out_n_o,
	input wire logic data_done_i,
	input wire logic load_enable_o,
	input wire logic user_mode_o,
	input wire logic error_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// counts raw supply time, so it is never shorter than the design's synced timer
	int sup_cnt;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sup_cnt <= 0;
		else
			sup_cnt <= supply_ok_i ? sup_cnt + 1 : 0;
	end
	property p_por; $fell(config_status_n_oe) |->
		sup_cnt >= (por_short_sel_i ? POR_SHORT : POR_LONG); endproperty
	a_por: assert property (p_por) else $error("status released early");
	property p_od; !config_status_n_o && !config_complete_flag_o; endproperty
	a_od: assert property (p_od) else $error("open-drain data not low");
	property p_done; $fell(config_complete_flag_oe) |-> $past(data_done_i) && !error_o; endproperty
	a_done: assert property (p_done) else $error("done released early");
	property p_user; user_mode_o |-> !config_complete_flag_oe && !chain_select_out_n_o; endproperty
	a_user: assert property (p_user) else $error("user mode outputs wrong");
	property p_enter; $rose(user_mode_o) |-> $past(config_complete_flag_i, 3); endproperty
	a_enter: assert property (p_enter) else $error("user mode with done low");
	property p_keep; $fell(user_mode_o) |->
		!$past(reconfig_request_n_i, 3) || !$past(supply_ok_i, 4); endproperty
	a_keep: assert property (p_keep) else $error("user mode lost");
	property p_load; $rose(load_enable_o) |->
		!config_status_n_oe && !$past(chip_select_in_n_i, 3); endproperty
	a_load: assert property (p_load) else $error("load accepted wrongly");
	property p_err; error_o |-> config_status_n_oe && !user_mode_o; endproperty
	a_err: assert property (p_err) else $error("error without status low");
endmodule : csh_config_status_assertions
bind csh_config_status csh_config_status_assertions #(.POR_SHORT(POR_SHORT),
	.POR_LONG(POR_LONG)) i_chk (.*);
`default_nettype wire

// >>> csh_host_model.sv
// external configuration host with pull-ups on both open-drain lines
// assumes the bench commands any low drive and the chip enable level
`timescale 1ns/10ps
`default_nettype none
module csh_host_model (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic status_oe_i,
	input wire logic done_oe_i,
	input wire logic pull_status_i,
	input wire logic pull_done_i,
	input wire logic cs_off_i,
	input wire logic [7:0] delay_i,
	output logic status_w_o,
	output logic done_w_o,
	output logic cs_n_o,
	output logic data_done_o
);
	logic [7:0] cnt;
	assign status_w_o = !(status_oe_i || pull_status_i);
	assign done_w_o = !(done_oe_i || pull_done_i);
	assign cs_n_o = cs_off_i;
	// a status low restarts the transfer; its rise is the start trigger
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
			data_done_o <= 1'h0;
		end else if (!status_w_o) begin
			cnt <= 8'h00;
			data_done_o <= 1'h0;
		end else if (cnt < delay_i) begin
			cnt <= cnt + 8'h01;
		end else begin
			data_done_o <= 1'h1;
		end
	end
endmodule : csh_host_model
`default_nettype wire

// >>> tb_config_status_handshake.sv
// self-checking bench for the configuration status handshake
// assumes the host model as far side; short power-on counts
`timescale 1ns/10ps
`default_nettype none
module tb_config_status_handshake;
	localparam int PS = 20;
	localparam int PL = 40;
	logic clock_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic supply = 1'h0;
	logic sel = 1'h1;
	logic reconf_n = 1'h1;
	logic pull_st = 1'h0;
	logic pull_dn = 1'h0;
	logic cs_off = 1'h0;
	logic derr = 1'h0;
	logic [7:0] dly = 8'h05;
	logic st_w, dn_w, cs_n, ddone, st_oe, dn_oe, chain_n, load_en, user, err;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	always #50 clock_i = ~clock_i;
	csh_config_status #(.POR_SHORT(PS), .POR_LONG(PL)) i_dut (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .supply_ok_i(supply), .por_short_sel_i(sel),
		.config_status_n_i(st_w), .config_status_n_o(), .config_status_n_oe(st_oe),
		.config_complete_flag_i(dn_w), .config_complete_flag_o(),
		.config_complete_flag_oe(dn_oe), .chip_select_in_n_i(cs_n),
		.reconfig_request_n_i(reconf_n), .chain_select_out_n_o(chain_n),
		.data_done_i(ddone), .data_error_i(derr), .load_enable_o(load_en),
		.user_mode_o(user), .error_o(err));
	csh_host_model i_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .status_oe_i(st_oe),
		.done_oe_i(dn_oe), .pull_status_i(pull_st), .pull_done_i(pull_dn),
		.cs_off_i(cs_off), .delay_i(dly), .status_w_o(st_w), .done_w_o(dn_w),
		.cs_n_o(cs_n), .data_done_o(ddone));
	task automatic results();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %b exp %b", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
	endtask : tick
	task automatic wait_user();
		for (n = 0; n < 300 && user !== 1'h1; n++) @(posedge clock_i);
		chk(user, 1'h1);
	endtask : wait_user
	task automatic pulse();
		reconf_n <= 1'h0;
		tick(10);
		chk(st_oe & dn_oe & !user, 1'h1);
		reconf_n <= 1'h1;
	endtask : pulse
	task automatic t_power(input logic s, input int por);
		supply <= 1'h0;
		sel <= s;
		tick(8);
		chk(st_oe, 1'h1);
		chk(load_en | user, 1'h0);
		supply <= 1'h1;
		for (n = 0; n < 300 && st_oe !== 1'h0; n++) @(posedge clock_i);
		chk(n >= por && n <= por + 8, 1'h1);
		wait_user();
		chk(dn_oe | chain_n, 1'h0);
	endtask : t_power
	task automatic t_init();
		pull_dn <= 1'h1;
		pulse();
		tick(60);
		chk(user | dn_oe, 1'h0);
		pull_dn <= 1'h0;
		wait_user();
	endtask : t_init
	task automatic t_user();
		pull_st <= 1'h1;
		pull_dn <= 1'h1;
		tick(12);
		chk(user & !err, 1'h1);
		pull_st <= 1'h0;
		pull_dn <= 1'h0;
		tick(2);
	endtask : t_user
	task automatic t_err();
		dly <= 8'h3C;
		pulse();
		for (n = 0; n < 100 && load_en !== 1'h1; n++) @(posedge clock_i);
		chk(load_en, 1'h1);
		pull_st <= 1'h1;
		tick(8);
		chk(err & st_oe, 1'h1);
		pull_st <= 1'h0;
		dly <= 8'h05;
		pulse();
		wait_user();
	endtask : t_err
	task automatic t_derr();
		dly <= 8'h3C;
		pulse();
		for (n = 0; n < 100 && load_en !== 1'h1; n++) @(posedge clock_i);
		derr <= 1'h1;
		tick(1);
		derr <= 1'h0;
		tick(2);
		chk(err & st_oe & !user, 1'h1);
		dly <= 8'h05;
		pulse();
		wait_user();
	endtask : t_derr
	task automatic t_cs();
		cs_off <= 1'h1;
		pulse();
		tick(60);
		chk(load_en | user, 1'h0);
		cs_off <= 1'h0;
		wait_user();
	endtask : t_cs
	initial begin
		tick(4);
		rst_n_i <= 1'h1;
		t_power(1'h1, PS);
		t_power(1'h0, PL);
		t_init();
		t_user();
		t_err();
		t_derr();
		t_cs();
		results();
	end
endmodule : tb_config_status_handshake
`default_nettype wire
